// [verilog/ptcf_top.sv]
// PTP stamp calculation with egress packing queue and APB registers.
// Assumes one clock; analyzer and rewriter sit on pclk.
// What this block does
// - Outputs corrected stamp or 64-bit correction
// - Ingress stamp is raw minus latencies
// - Egress stamp is raw plus latencies
// - Derives stamp ns and path-delayed ns
// - Path delay added into every event correction
// - Holds signed 32-bit asymmetry value
// - Add bit adds sign-extended asymmetry
// - Subtract bit subtracts sign-extended asymmetry
// - Calculation uses shadow copies of latency, path delay and asymmetry
// - Only event messages are ever updated
// - Store and overflow raise separate interrupts
// - Only configured signature bytes are stored
// - Full entry is 26 bytes
// - No signature gives 10 or 4 bytes
// - Packing register writes queue at 26 bytes
// - Word0 bit 31 flags empty queue
// - Reading last readout word pops queue
// - Drained queue takes partial packing register
// - Three flag bits encode set content
// - Threshold interrupt and readable fill level
// - Overflow inhibits writes, drops new stamps
// - Queue exists only for egress
`default_nettype none

module ptcf_top
  import ptcf_pkg::*;
(
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [7:0]   paddr,
  input  wire logic [31:0]  pwdata,
  output logic              pready,
  output logic              pslverr,
  output logic [31:0]       prdata,
  input  wire logic         calc_req,
  input  wire logic         calc_event,
  input  wire logic         calc_corr_mode,
  input  wire logic [79:0]  calc_raw_ts,
  input  wire logic [31:0]  calc_var_lat,
  input  wire logic [63:0]  calc_corr_in,
  input  wire logic [127:0] calc_sig,
  output logic              rw_valid,
  output logic              rw_update,
  output logic              rw_corr_mode,
  output logic [79:0]       rw_stamp,
  output logic [63:0]       rw_corr,
  output logic [63:0]       rw_ns,
  output logic [63:0]       rw_p2p_ns,
  output logic              irq,
  output logic              irq_ovf
);

  // Add nanoseconds to a {sec48, ns32} stamp, one wrap
  function automatic logic [79:0] ts_add(input logic [79:0] t,
                                         input logic [31:0] d);
    logic [32:0] s;
    s = {1'b0, t[31:0]} + {1'b0, d};
    if (s >= {1'b0, NS_PER_SEC}) begin
      ts_add = {t[79:32] + 48'h1, 32'(s - {1'b0, NS_PER_SEC})};
    end else begin
      ts_add = {t[79:32], s[31:0]};
    end
  endfunction

  function automatic logic [79:0] ts_sub(input logic [79:0] t,
                                         input logic [31:0] d);
    if (t[31:0] >= d) begin
      ts_sub = {t[79:32], t[31:0] - d};
    end else begin
      ts_sub = {t[79:32] - 48'h1, t[31:0] + NS_PER_SEC - d};
    end
  endfunction

  // Scaled-nanosecond form of a ns count
  function automatic logic [63:0] scaled(input logic [63:0] ns);
    scaled = ns << SCALE_SH;
  endfunction

  // Registers
  logic [31:0]      asym_q, loclat_q, path_q, mask_q;
  logic [4:0]       sig_len_q;
  logic             short_q, asym_add_q, asym_sub_q, egress_q;
  logic [LVL_W-1:0] thr_q;
  logic [2:0]       stat_q;
  logic [31:0]      sh_loclat_q, sh_path_q, sh_asym_q;
  logic [31:0]      prdata_q;

  logic setup, acc_wr, acc_rd, mapped;
  assign setup  = psel & ~penable;
  assign acc_wr = psel & penable & pwrite;
  assign acc_rd = psel & penable & ~pwrite;
  assign pready = 1'b1;
  assign prdata = prdata_q;

  always_comb begin
    if (paddr[1:0] != 2'b00) begin
      mapped = 1'b0;
    end else if (paddr <= OFF_MASK) begin
      mapped = 1'b1;
    end else begin
      mapped = 1'b0;
    end
  end
  assign pslverr = psel & penable & ~mapped;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      asym_q     <= REG_RST;
      loclat_q   <= REG_RST;
      path_q     <= REG_RST;
      mask_q     <= REG_RST;
      sig_len_q  <= 5'h00;
      short_q    <= 1'b0;
      thr_q      <= '0;
      asym_add_q <= 1'b0;
      asym_sub_q <= 1'b0;
      egress_q   <= 1'b0;
    end else if (acc_wr) begin
      if (paddr == OFF_ASYM) begin
        asym_q <= pwdata;
      end else if (paddr == OFF_QCTRL) begin
        sig_len_q <= (pwdata[QC_SIG_LSB +: 5] > SIG_MAX) ?
                     SIG_MAX : pwdata[QC_SIG_LSB +: 5];
        short_q   <= pwdata[QC_SHORT];
        thr_q     <= pwdata[QC_THR_LSB +: LVL_W];
      end else if (paddr == OFF_LOCLAT) begin
        loclat_q <= pwdata;
      end else if (paddr == OFF_PATH) begin
        path_q <= pwdata;
      end else if (paddr == OFF_CCTRL) begin
        asym_add_q <= pwdata[CC_ADD];
        asym_sub_q <= pwdata[CC_SUB];
        egress_q   <= pwdata[CC_EGR];
      end else if (paddr == OFF_MASK) begin
        mask_q <= pwdata;
      end
    end
  end

  // shadows freeze while a request is taken
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sh_loclat_q <= REG_RST;
      sh_path_q   <= REG_RST;
      sh_asym_q   <= REG_RST;
    end else if (!calc_req) begin
      sh_loclat_q <= loclat_q;
      sh_path_q   <= path_q;
      sh_asym_q   <= asym_q;
    end
  end

  // Calculation
  logic [31:0] lat_sum;
  logic [79:0] act_ts;
  logic [63:0] act_ns, p2p_ns, corr_base, corr_d, asym_ext;
  assign lat_sum  = sh_loclat_q + calc_var_lat;
  assign asym_ext = {{32{sh_asym_q[31]}}, sh_asym_q};

  always_comb begin
    if (egress_q) begin
      act_ts = ts_add(calc_raw_ts, lat_sum);
    end else begin
      act_ts = ts_sub(calc_raw_ts, lat_sum);
    end
    act_ns = 64'(act_ts[79:32]) * 64'(NS_PER_SEC) + 64'(act_ts[31:0]);
    p2p_ns = act_ns + 64'(sh_path_q);
    if (egress_q) begin
      corr_base = calc_corr_in + scaled(act_ns) + scaled(64'(sh_path_q));
    end else begin
      corr_base = calc_corr_in - scaled(act_ns) + scaled(64'(sh_path_q));
    end
    corr_d = corr_base;
    if (asym_add_q) begin
      corr_d = corr_d + asym_ext;
    end
    if (asym_sub_q) begin
      corr_d = corr_d - asym_ext;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rw_valid     <= 1'b0;
      rw_update    <= 1'b0;
      rw_corr_mode <= 1'b0;
      rw_stamp     <= '0;
      rw_corr      <= '0;
      rw_ns        <= '0;
      rw_p2p_ns    <= '0;
    end else begin
      rw_valid <= calc_req;
      if (calc_req) begin
        rw_update    <= calc_event;
        rw_corr_mode <= calc_corr_mode;
        rw_stamp     <= act_ts;
        rw_corr      <= calc_event ? corr_d : calc_corr_in;
        rw_ns        <= act_ns;
        rw_p2p_ns    <= p2p_ns;
      end
    end
  end

  // Entry build: stamp low, signature above
  logic [SET_W-1:0] entry_d, entry_q;
  logic [CNT_W-1:0] elen_d, elen_q;
  logic             ev_q;
  logic [127:0]     sig_mask;

  always_comb begin
    sig_mask = ~({128{1'b1}} << {sig_len_q, 3'b000});
    if (short_q) begin
      entry_d = SET_W'(act_ts[31:0]) |
                (SET_W'(calc_sig & sig_mask) << 32);
      elen_d  = TS_SH_BYTES + CNT_W'(sig_len_q);
    // up to 80 plus 128 bits
    end else begin
      entry_d = SET_W'(act_ts) | (SET_W'(calc_sig & sig_mask) << 80);
      elen_d  = TS_BYTES + CNT_W'(sig_len_q);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ev_q    <= 1'b0;
      entry_q <= '0;
      elen_q  <= '0;
    end else begin
      ev_q    <= calc_req & calc_event & egress_q;
      entry_q <= entry_d;
      elen_q  <= elen_d;
    end
  end

  // Queue storage
  logic [SET_W+2:0] mem_q [FIFO_DEPTH];
  logic [PTR_W-1:0] wp_q, rp_q;
  logic [LVL_W-1:0] lvl_q;
  logic             empty, full, pop, push, flush_q;
  logic [SET_W+2:0] push_data, head;
  assign empty = (lvl_q == '0);
  assign full  = (lvl_q == LVL_FULL);
  assign head  = mem_q[rp_q];
  assign pop   = acc_rd & (paddr == OFF_RD6) & ~empty;

  // Packing register
  logic [BUF_W-1:0] buf_q, buf_d, base_buf;
  logic [CNT_W-1:0] cnt_q, cnt_d, base_cnt;
  logic [2:0]       lo_q, hi_q, lo_d, hi_d;
  logic             set_full, do_full, do_flush, append, ovf_set;

  always_comb begin
    // full set when 26 bytes valid
    set_full = (cnt_q >= SET_BYTES);
    do_full  = set_full & ~full & ~stat_q[ST_OVF];
    do_flush = flush_q & ~set_full & (cnt_q != '0) & ~full &
               ~stat_q[ST_OVF];
    push     = do_full | do_flush;
    ovf_set  = (set_full | ev_q) & full;
    base_buf = buf_q;
    base_cnt = cnt_q;
    lo_d     = lo_q;
    hi_d     = hi_q;
    push_data = '0;
    if (do_full) begin
      push_data = {FLAGS_FULL, buf_q[SET_W-1:0]};
      base_buf  = buf_q >> SET_W;
      base_cnt  = cnt_q - SET_BYTES;
      lo_d      = hi_q;
      hi_d      = 3'h0;
    end else if (do_flush) begin
      // count of entries begun, capped at 6
      push_data = {(lo_q > FLAGS_MAXCNT) ? FLAGS_MAXCNT : lo_q,
                   buf_q[SET_W-1:0]};
      base_buf  = '0;
      base_cnt  = '0;
      lo_d      = 3'h0;
      hi_d      = 3'h0;
    end
    append = ev_q & ~stat_q[ST_OVF] & ~ovf_set & (base_cnt < SET_BYTES);
    buf_d  = base_buf;
    cnt_d  = base_cnt;
    if (append) begin
      buf_d = base_buf | (BUF_W'(entry_q) << {base_cnt, 3'b000});
      cnt_d = base_cnt + elen_q;
      if (base_cnt < SET_BYTES) begin
        lo_d = lo_d + 3'h1;
      end else begin
        hi_d = hi_d + 3'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buf_q   <= '0;
      cnt_q   <= '0;
      lo_q    <= 3'h0;
      hi_q    <= 3'h0;
      flush_q <= 1'b0;
    end else begin
      buf_q   <= buf_d;
      cnt_q   <= cnt_d;
      lo_q    <= lo_d;
      hi_q    <= hi_d;
      flush_q <= pop & (lvl_q == LVL_W'(1)) & ~push;
    end
  end

  always_ff @(posedge pclk) begin
    if (push) begin
      mem_q[wp_q] <= push_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp_q  <= '0;
      rp_q  <= '0;
      lvl_q <= '0;
    end else begin
      if (push) begin
        wp_q <= wp_q + PTR_W'(1);
      end
      if (pop) begin
        rp_q <= rp_q + PTR_W'(1);
      end
      if (push & ~pop) begin
        lvl_q <= lvl_q + LVL_W'(1);
      end else if (pop & ~push) begin
        lvl_q <= lvl_q - LVL_W'(1);
      end
    end
  end

  // Sticky status, write one to clear, set wins
  logic [2:0] st_set, st_clr;
  always_comb begin
    st_set = 3'b000;
    st_set[ST_STORED] = append;
    st_set[ST_OVF]    = ovf_set;
    st_set[ST_THR]    = (thr_q != '0) & (lvl_q >= thr_q);
    st_clr = (acc_wr & (paddr == OFF_STAT)) ? pwdata[2:0] : 3'b000;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_q <= 3'b000;
    end else begin
      stat_q <= (stat_q & ~st_clr) | st_set;
    end
  end

  assign irq     = (stat_q[ST_STORED] & mask_q[ST_STORED]) |
                   (stat_q[ST_THR] & mask_q[ST_THR]);
  assign irq_ovf = stat_q[ST_OVF] & mask_q[ST_OVF];

  // Read data captured in the setup cycle
  logic [31:0] rd_mux;
  logic [2:0]  rd_idx;
  assign rd_idx = paddr[4:2];

  always_comb begin
    rd_mux = 32'h00000000;
    if (paddr == OFF_RD0) begin
      // empty flag and 16 data bits
      rd_mux[RD0_EMPTY] = empty;
      if (!empty) begin
        rd_mux[RD0_FLAGS +: 3] = head[SET_W +: 3];
        rd_mux[15:0]           = head[15:0];
      end
    end else if (paddr <= OFF_RD6 && paddr[1:0] == 2'b00) begin
      if (!empty) begin
        rd_mux = head[16 + 32 * (32'(rd_idx) - 1) +: 32];
      end
    end else if (paddr == OFF_ASYM) begin
      rd_mux = asym_q;
    end else if (paddr == OFF_QCTRL) begin
      rd_mux[QC_SIG_LSB +: 5]   = sig_len_q;
      rd_mux[QC_SHORT]          = short_q;
      rd_mux[QC_THR_LSB +: LVL_W] = thr_q;
      rd_mux[QC_LVL_LSB +: LVL_W] = lvl_q;
    end else if (paddr == OFF_LOCLAT) begin
      rd_mux = loclat_q;
    end else if (paddr == OFF_PATH) begin
      rd_mux = path_q;
    end else if (paddr == OFF_CCTRL) begin
      rd_mux[CC_ADD] = asym_add_q;
      rd_mux[CC_SUB] = asym_sub_q;
      rd_mux[CC_EGR] = egress_q;
    end else if (paddr == OFF_STAT) begin
      rd_mux[2:0] = stat_q;
    end else if (paddr == OFF_MASK) begin
      rd_mux = mask_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= REG_RST;
    end else if (setup) begin
      prdata_q <= rd_mux;
    end
  end

endmodule

`default_nettype wire

// [verilog/ptcf_pkg.sv]
// Constants for the PTP stamp calculation and egress stamp queue.
// Assumes a 32-bit APB slave with byte addresses in the low 8 bits.
`default_nettype none

package ptcf_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_RD0    = 8'h00;
  localparam logic [7:0] OFF_RD6    = 8'h18;
  localparam logic [7:0] OFF_ASYM   = 8'h1C;
  localparam logic [7:0] OFF_QCTRL  = 8'h20;
  localparam logic [7:0] OFF_LOCLAT = 8'h24;
  localparam logic [7:0] OFF_PATH   = 8'h28;
  localparam logic [7:0] OFF_CCTRL  = 8'h2C;
  localparam logic [7:0] OFF_STAT   = 8'h30;
  localparam logic [7:0] OFF_MASK   = 8'h34;

  // Queue sizing
  localparam int unsigned FIFO_DEPTH = 8;
  localparam int unsigned LVL_W      = 4;
  localparam int unsigned PTR_W      = 3;
  localparam int unsigned SET_W      = 208;
  localparam int unsigned BUF_W      = 416;
  localparam int unsigned CNT_W      = 6;
  localparam logic [CNT_W-1:0] SET_BYTES   = 6'h1A;
  localparam logic [CNT_W-1:0] TS_BYTES    = 6'h0A;
  localparam logic [CNT_W-1:0] TS_SH_BYTES = 6'h04;
  localparam logic [4:0]       SIG_MAX     = 5'h10;
  localparam logic [LVL_W-1:0] LVL_FULL    = 4'h8;
  localparam logic [2:0] FLAGS_FULL   = 3'h7;
  localparam logic [2:0] FLAGS_MAXCNT = 3'h6;

  // Field positions
  localparam int unsigned QC_SIG_LSB = 0;
  localparam int unsigned QC_SHORT   = 5;
  localparam int unsigned QC_THR_LSB = 8;
  localparam int unsigned QC_LVL_LSB = 16;
  localparam int unsigned CC_ADD     = 0;
  localparam int unsigned CC_SUB     = 1;
  localparam int unsigned CC_EGR     = 2;
  localparam int unsigned ST_STORED  = 0;
  localparam int unsigned ST_OVF     = 1;
  localparam int unsigned ST_THR     = 2;
  localparam int unsigned RD0_EMPTY  = 31;
  localparam int unsigned RD0_FLAGS  = 28;

  // Time constants and register reset value
  localparam logic [31:0] NS_PER_SEC = 32'h3B9ACA00;
  localparam int unsigned SCALE_SH   = 16;
  localparam logic [31:0] REG_RST    = 32'h00000000;
endpackage

`default_nettype wire

// [verification/ptcf_top_chk.sv]
// Concurrent checks on the ports of ptcf_top.
// Assumes one pclk domain; bound to the design top below.
`default_nettype none

module ptcf_top_chk
  import ptcf_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] prdata,
  input wire logic        calc_req,
  input wire logic        calc_event,
  input wire logic [63:0] calc_corr_in,
  input wire logic        rw_valid,
  input wire logic        rw_update,
  input wire logic [79:0] rw_stamp,
  input wire logic [63:0] rw_corr,
  input wire logic [63:0] rw_ns,
  input wire logic        irq_ovf
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_acc;
    psel && !penable ##1 psel && penable;
  endsequence

  sequence s_bad_rd;
    psel && !penable && !pwrite && paddr > OFF_MASK ##1 psel && penable;
  endsequence

  AST_READY: assert property (s_acc |-> pready)
    else $error("access phase without ready");
  AST_UNMAP: assert property (s_bad_rd |-> pslverr && prdata == 32'h0)
    else $error("unmapped read not refused");
  AST_VALID: assert property (1'b1 |=> rw_valid == $past(calc_req))
    else $error("result strobe not one cycle after request");
  AST_UPD: assert property (calc_req |=> rw_update == $past(calc_event))
    else $error("update flag differs from event kind");
  AST_FOLLOW: assert property (
    calc_req && !calc_event |=> rw_corr == $past(calc_corr_in))
    else $error("follow-up correction altered");
  AST_NS: assert property (rw_valid |->
    rw_ns == 64'(rw_stamp[79:32]) * 64'(NS_PER_SEC) + 64'(rw_stamp[31:0]))
    else $error("nanosecond total wrong");
  AST_EMPTY: assert property (
    psel && penable && !pwrite && paddr == OFF_RD0 && prdata[RD0_EMPTY]
    |-> prdata[30:0] == 31'h0)
    else $error("empty readout carries data");
  AST_OVF: assert property (irq_ovf && !(psel && pwrite) |=> irq_ovf)
    else $error("overflow flag dropped without write");
endmodule

bind ptcf_top ptcf_top_chk i_chk (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pready, .pslverr,
  .prdata, .calc_req, .calc_event, .calc_corr_in, .rw_valid, .rw_update,
  .rw_stamp, .rw_corr, .rw_ns, .irq_ovf
);

`default_nettype wire

// [verification/ptcf_far_model.sv]
// Analyzer and rewriter stand-in: issues stamp requests, keeps results.
// Assumes the bench calls send; data lines other than calc_corr_mode are scrambled between requests.
`default_nettype none

module ptcf_far_model (
  input  wire logic         pclk,
  input  wire logic         rw_valid,
  input  wire logic         rw_update,
  input  wire logic [79:0]  rw_stamp,
  input  wire logic [63:0]  rw_corr,
  input  wire logic [63:0]  rw_ns,
  input  wire logic [63:0]  rw_p2p_ns,
  output logic              calc_req,
  output logic              calc_event,
  output logic              calc_corr_mode,
  output logic [79:0]       calc_raw_ts,
  output logic [31:0]       calc_var_lat,
  output logic [63:0]       calc_corr_in,
  output logic [127:0]      calc_sig
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        got_v;
  logic        got_u;
  logic [79:0] got_st;
  logic [63:0] got_c;
  logic [63:0] got_ns;
  logic [63:0] got_p2p;

  initial begin
    calc_req       = 1'b0;
    calc_event     = 1'b0;
    calc_corr_mode = 1'b0;
    calc_raw_ts    = '0;
    calc_var_lat   = 32'h0;
    calc_corr_in   = 64'h0;
    calc_sig       = '0;
  end

  task automatic send(input logic ev, input logic [79:0] raw,
                      input logic [63:0] ci, input logic [127:0] sg);
    @(posedge pclk);
    calc_req       <= 1'b1;
    calc_event     <= ev;
    calc_corr_mode <= ev;
    calc_raw_ts    <= raw;
    calc_var_lat   <= 32'h14;
    calc_corr_in   <= ci;
    calc_sig       <= sg;
    @(posedge pclk);
    calc_req     <= 1'b0;
    calc_event   <= ~ev;
    calc_raw_ts  <= ~raw;
    calc_var_lat <= 32'hFFFFFFEB;
    calc_corr_in <= ~ci;
    calc_sig     <= ~sg;
    // Results are sampled mid-cycle, while the result strobe stands
    @(negedge pclk);
    got_v   = rw_valid;
    got_u   = rw_update;
    got_st  = rw_stamp;
    got_c   = rw_corr;
    got_ns  = rw_ns;
    got_p2p = rw_p2p_ns;
    @(posedge pclk);
  endtask
endmodule

`default_nettype wire

// [verification/ptcf_top_tb_top.sv]
// Bench for ptcf_top: APB register tests, stamp math and queue packing.
// Assumes ptcf_far_model for stamp traffic and the bound checker.
`default_nettype none

module ptcf_top_tb_top import ptcf_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic         pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic         calc_req, calc_event, calc_corr_mode, rw_valid, e;
  logic         rw_update, rw_corr_mode, irq, irq_ovf;
  logic [7:0]   paddr;
  logic [31:0]  pwdata, prdata, calc_var_lat, r;
  logic [31:0]  w [7];
  logic [79:0]  calc_raw_ts, rw_stamp;
  logic [63:0]  calc_corr_in, rw_corr, rw_ns, rw_p2p_ns, c_add;
  logic [127:0] calc_sig;
  int           error_cnt, check_count;

  ptcf_top i_dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .pslverr, .prdata, .calc_req, .calc_event, .calc_corr_mode,
    .calc_raw_ts, .calc_var_lat, .calc_corr_in, .calc_sig, .rw_valid,
    .rw_update, .rw_corr_mode, .rw_stamp, .rw_corr, .rw_ns, .rw_p2p_ns,
    .irq, .irq_ovf
  );

  ptcf_far_model i_far (
    .pclk, .rw_valid, .rw_update, .rw_stamp, .rw_corr, .rw_ns, .rw_p2p_ns,
    .calc_req, .calc_event, .calc_corr_mode, .calc_raw_ts, .calc_var_lat,
    .calc_corr_in, .calc_sig
  );

  task automatic chk(input logic [79:0] got, input logic [79:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(80'(r), 80'(x));
  endtask

  task automatic rd_set;
    for (int k = 0; k < 7; k++) begin
      apb(1'b0, 8'(4 * k), 32'h0);
      w[k] = r;
    end
  endtask

  task automatic st(input logic ev, input logic [79:0] raw);
    i_far.send(ev, raw, 64'h1234, {32'hC0DE0000 + raw[31:0], 96'h0});
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  initial begin
    repeat (6000) @(posedge pclk);
    error_cnt++;
    stop_test;
  end

  initial begin
    error_cnt = 0;
    check_count = 0;
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rd(OFF_QCTRL, 32'h0);
    rd(OFF_RD0, 32'h80000000);
    apb(1'b0, 8'h38, 32'h0);
    chk(80'({e, r}), 80'({1'b1, 32'h0}));
    wr(OFF_ASYM, 32'hFFFFFFFD);
    rd(OFF_ASYM, 32'hFFFFFFFD);
    wr(OFF_LOCLAT, 32'h64);
    wr(OFF_PATH, 32'h7);
    wr(OFF_CCTRL, 32'h4);
    $display("register test done");
    st(1'b0, {48'h1, 32'h1F4});
    chk(i_far.got_st, {48'h1, 32'h26C});
    chk(80'(i_far.got_ns), 80'(64'(NS_PER_SEC) + 64'h26C));
    chk(80'(i_far.got_p2p), 80'(64'(NS_PER_SEC) + 64'h273));
    chk(80'({i_far.got_v, i_far.got_u, i_far.got_c}),
        80'({1'b1, 1'b0, 64'h1234}));
    wr(OFF_CCTRL, 32'h1);
    st(1'b1, {48'h2, 32'h32});
    chk(i_far.got_st, {48'h1, NS_PER_SEC - 32'h46});
    chk(80'(rw_corr_mode), 80'h1);
    c_add = i_far.got_c;
    wr(OFF_CCTRL, 32'h2);
    st(1'b1, {48'h2, 32'h32});
    chk(80'(i_far.got_c - c_add), 80'h6);
    wr(OFF_PATH, 32'h9);
    wr(OFF_CCTRL, 32'h0);
    st(1'b1, {48'h2, 32'h32});
    chk(80'(i_far.got_c - c_add), 80'h20003);
    rd(OFF_QCTRL, 32'h0);
    rd(OFF_RD0, 32'h80000000);
    $display("calculation test done");
    wr(OFF_MASK, 32'h7);
    wr(OFF_QCTRL, 32'h214);
    wr(OFF_CCTRL, 32'h4);
    for (int i = 1; i < 3; i++) st(1'b1, {48'hABCD, 16'(i), 16'h5678});
    rd(OFF_QCTRL, 32'h00020210);
    chk(80'(irq), 80'h1);
    wr(OFF_MASK, 32'h0);
    @(posedge pclk);
    chk(80'(irq), 80'h0);
    for (int i = 1; i < 3; i++) begin
      rd_set;
      chk(80'({w[0], w[1]}), 80'({32'h700056F0, 16'hABCD, 16'(i)}));
      chk(80'(w[6]), 80'(32'hC0DE5678 + {16'(i), 16'h0}));
    end
    rd(OFF_RD0, 32'h80000000);
    wr(OFF_STAT, 32'h7);
    wr(OFF_MASK, 32'h7);
    @(posedge pclk);
    chk(80'(irq), 80'h0);
    $display("full set test done");
    wr(OFF_QCTRL, 32'h20);
    for (int i = 1; i < 9; i++) begin
      st(1'b1, {48'h5, 16'(16'hA0 + i), 16'(16'hB0 + i)});
    end
    rd(OFF_QCTRL, 32'h00010020);
    rd_set;
    chk(80'({w[0], w[1]}), 80'({32'h70000129, 32'h012A00A1}));
    rd_set;
    chk(80'({w[0], w[1]}), 80'({32'h100000A7, 32'h00A80130}));
    rd(OFF_RD0, 32'h80000000);
    $display("partial set test done");
    wr(OFF_QCTRL, 32'h10);
    wr(OFF_STAT, 32'h7);
    for (int i = 1; i < 11; i++) st(1'b1, {48'h7, 16'(i), 16'h1});
    rd(OFF_QCTRL, 32'h00080010);
    chk(80'({irq_ovf, irq}), 80'h3);
    for (int i = 1; i < 9; i++) begin
      rd_set;
      chk(80'({w[0], w[1]}), 80'({32'h70000079, 16'h7, 16'(i)}));
    end
    rd(OFF_RD0, 32'h80000000);
    wr(OFF_STAT, 32'h2);
    @(posedge pclk);
    chk(80'(irq_ovf), 80'h0);
    $display("overflow test done");
    stop_test;
  end
endmodule

`default_nettype wire
